/* core/swtc_map.vh */
// register addresses, field layout, reset values and timing for the sleep wake timer block
`ifndef SWTC_MAP_VH
`define SWTC_MAP_VH
// spi frame layout
`define SWTC_FRAME_W       32
`define SWTC_ADDR_HI       31
`define SWTC_ADDR_LO       25
`define SWTC_RW_BIT        24
`define SWTC_DATA_W        24
`define SWTC_FAULT_BIT     23
`define SWTC_IRQ_BIT       22
// register addresses (7-bit)
`define SWTC_ADDR_CFG      7'h0F
`define SWTC_ADDR_WMSEL    7'h10
`define SWTC_ADDR_WMGND    7'h11
// reset values
`define SWTC_CFG_RST       8'h0F
`define SWTC_WMSEL_RST     8'hFF
`define SWTC_WMGND_RST     14'h3FFF
`define SWTC_WMSEL_W       8
`define SWTC_WMGND_W       14
// config fields
`define SWTC_WAKE_HI       7
`define SWTC_WAKE_LO       4
`define SWTC_POLL_HI       3
`define SWTC_POLL_LO       0
`define SWTC_WAKE_OFF      4'h0
// timing: 25 MHz clock, 25000 cycles per ms
`define SWTC_CLK_KHZ       25000
`define SWTC_TICK_W        15
`define SWTC_MS_W          10
`define SWTC_ACTIVE_US     100
`define SWTC_ACTIVE_CYC    ((`SWTC_ACTIVE_US * `SWTC_CLK_KHZ) / 1000)
`define SWTC_ACT_W         12
// last count of the ms prescaler and of the active window, sized for their counters
`define SWTC_MS_LAST       15'h61A7
`define SWTC_ACT_LAST      12'h9C3
// wake timer period in ms for each code
`define SWTC_WAKE_MS_OFF   10'h000
`define SWTC_WAKE_MS_1     10'h006
`define SWTC_WAKE_MS_2     10'h00C
`define SWTC_WAKE_MS_3     10'h018
`define SWTC_WAKE_MS_4     10'h030
`define SWTC_WAKE_MS_5     10'h060
`define SWTC_WAKE_MS_6     10'h0C0
`define SWTC_WAKE_MS_7     10'h18A
`define SWTC_WAKE_MS_8     10'h004
`define SWTC_WAKE_MS_9     10'h008
`define SWTC_WAKE_MS_A     10'h010
`define SWTC_WAKE_MS_B     10'h020
`define SWTC_WAKE_MS_C     10'h040
`define SWTC_WAKE_MS_D     10'h080
`define SWTC_WAKE_MS_E     10'h100
`define SWTC_WAKE_MS_F     10'h200
// polling interval in ms for each code
`define SWTC_POLL_MS_0     10'h003
`define SWTC_POLL_MS_1     10'h006
`define SWTC_POLL_MS_2     10'h00C
`define SWTC_POLL_MS_3     10'h018
`define SWTC_POLL_MS_4     10'h030
`define SWTC_POLL_MS_5     10'h044
`define SWTC_POLL_MS_6     10'h04C
`define SWTC_POLL_MS_7     10'h080
`define SWTC_POLL_MS_8     10'h020
`define SWTC_POLL_MS_9     10'h024
`define SWTC_POLL_MS_A     10'h028
`define SWTC_POLL_MS_B     10'h02C
`define SWTC_POLL_MS_C     10'h034
`define SWTC_POLL_MS_D     10'h038
`define SWTC_POLL_MS_E     10'h03C
`define SWTC_POLL_MS_F     10'h040
`endif

/* core/swtc_ms_timer.v */
// millisecond down counter that pulses when a loaded period expires
`timescale 1ns/1ps
`default_nettype none
`include "swtc_map.vh"
module swtc_ms_timer
(
   input  wire                     clk,
   input  wire                     reset,
   input  wire                     run,
   input  wire [`SWTC_MS_W-1:0]    period_ms,
   input  wire                     ms_tick,
   output reg                      expired
);
   reg [`SWTC_MS_W-1:0] count;

   always @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         count   <= {`SWTC_MS_W{1'b0}};
         expired <= 1'b0;
      end
      else
      begin
         expired <= 1'b0;
         if (!run)
            count <= period_ms;
         else if (ms_tick)
         begin
            if (count <= {{(`SWTC_MS_W-1){1'b0}}, 1'b1})
            begin
               expired <= 1'b1;
               count   <= period_ms;
            end
            else
               count <= count - {{(`SWTC_MS_W-1){1'b0}}, 1'b1};
         end
      end
   end
endmodule
`default_nettype wire

/* core/swtc_core.v */
// sleep-mode wake timer, polling timer and wake masks behind a 32-bit spi register frame
// Functional notes
// - bits 7-4 pick wake timer; 0000 off (reset), other codes map to ms.
// - bits 3-0 pick polling interval; reset 1111 is 64 ms.
// - in sleep, wake timer expiry wakes and raises irq; off never wakes.
// - each poll event enables current sources for a fixed window, then samples.
// - channel with wake bit clear never wakes the device.
// - channel with wake bit set wakes the device on any state change.
// - host may rewrite masks anytime in normal mode; applied immediately.
// - all implemented wake enable bits read one after reset.
// - all wake bits clear stops the polling timer throughout sleep.
// - selectable mask at 0010_000, bits 7-0; bits 23-8 read zero.
// - ground mask at 0010_001; bits 23-14 unused, zero.
// - frame is address 31-25, read/write 24, data 23-0.
`timescale 1ns/1ps
`default_nettype none
`include "swtc_map.vh"
module swtc_core
(
   input  wire                         clk,
   input  wire                         reset,
   input  wire                         frame_valid,
   input  wire [`SWTC_FRAME_W-1:0]     frame_in,
   input  wire                         fault_summary,
   input  wire                         sleep_mode,
   input  wire [`SWTC_WMSEL_W-1:0]     selectable_channel_state,
   input  wire [`SWTC_WMGND_W-1:0]     ground_switch_channel_state,
   input  wire                         irq_clear,
   output reg  [`SWTC_FRAME_W-1:0]     frame_out,
   output reg                          frame_out_valid,
   output reg                          wake_request,
   output reg                          irq_pending_flag,
   output reg                          current_source_en,
   output reg                          sample_strobe,
   output reg                          poll_running
);
   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   reg  [7:0]                 sleep_timer_config;
   reg  [`SWTC_WMSEL_W-1:0]   wake_mask_selectable;
   reg  [`SWTC_WMGND_W-1:0]   wake_mask_ground;
   reg  [`SWTC_DATA_W-1:0]    next_read;

   wire [6:0] addr   = frame_in[`SWTC_ADDR_HI:`SWTC_ADDR_LO];
   wire       is_wr  = frame_in[`SWTC_RW_BIT];
   wire [`SWTC_DATA_W-1:0] wdata = frame_in[`SWTC_DATA_W-1:0];

   always @*
   begin
      case (addr)
         `SWTC_ADDR_CFG:   next_read = {16'h0000, sleep_timer_config};
         `SWTC_ADDR_WMSEL: next_read = {16'h0000, wake_mask_selectable};
         `SWTC_ADDR_WMGND: next_read = {10'h000, wake_mask_ground};
         default:          next_read = 24'h000000;
      endcase
   end

   always @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         sleep_timer_config   <= `SWTC_CFG_RST;
         wake_mask_selectable <= `SWTC_WMSEL_RST;
         wake_mask_ground     <= `SWTC_WMGND_RST;
         frame_out            <= 32'h00000000;
         frame_out_valid      <= 1'b0;
      end
      else
      begin
         frame_out_valid <= frame_valid;
         if (frame_valid)
         begin
            // reply carries status flags over the pre-write register content
            frame_out <= {addr, is_wr, fault_summary, irq_pending_flag,
                          next_read[21:0]};
            if (is_wr && !sleep_mode)
            begin
               case (addr)
                  `SWTC_ADDR_CFG:   sleep_timer_config   <= wdata[7:0];
                  `SWTC_ADDR_WMSEL: wake_mask_selectable <= wdata[`SWTC_WMSEL_W-1:0];
                  `SWTC_ADDR_WMGND: wake_mask_ground     <= wdata[`SWTC_WMGND_W-1:0];
                  default:          ;
               endcase
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // period decode
   // ----------------------------------------------------------------
   wire [3:0] wake_code = sleep_timer_config[`SWTC_WAKE_HI:`SWTC_WAKE_LO];
   wire [3:0] poll_code = sleep_timer_config[`SWTC_POLL_HI:`SWTC_POLL_LO];
   reg  [`SWTC_MS_W-1:0] wake_ms;
   reg  [`SWTC_MS_W-1:0] poll_ms;

   always @*
   begin
      case (wake_code)
         4'h1:    wake_ms = `SWTC_WAKE_MS_1;
         4'h2:    wake_ms = `SWTC_WAKE_MS_2;
         4'h3:    wake_ms = `SWTC_WAKE_MS_3;
         4'h4:    wake_ms = `SWTC_WAKE_MS_4;
         4'h5:    wake_ms = `SWTC_WAKE_MS_5;
         4'h6:    wake_ms = `SWTC_WAKE_MS_6;
         4'h7:    wake_ms = `SWTC_WAKE_MS_7;
         4'h8:    wake_ms = `SWTC_WAKE_MS_8;
         4'h9:    wake_ms = `SWTC_WAKE_MS_9;
         4'hA:    wake_ms = `SWTC_WAKE_MS_A;
         4'hB:    wake_ms = `SWTC_WAKE_MS_B;
         4'hC:    wake_ms = `SWTC_WAKE_MS_C;
         4'hD:    wake_ms = `SWTC_WAKE_MS_D;
         4'hE:    wake_ms = `SWTC_WAKE_MS_E;
         4'hF:    wake_ms = `SWTC_WAKE_MS_F;
         default: wake_ms = `SWTC_WAKE_MS_OFF;
      endcase
   end

   always @*
   begin
      case (poll_code)
         4'h0:    poll_ms = `SWTC_POLL_MS_0;
         4'h1:    poll_ms = `SWTC_POLL_MS_1;
         4'h2:    poll_ms = `SWTC_POLL_MS_2;
         4'h3:    poll_ms = `SWTC_POLL_MS_3;
         4'h4:    poll_ms = `SWTC_POLL_MS_4;
         4'h5:    poll_ms = `SWTC_POLL_MS_5;
         4'h6:    poll_ms = `SWTC_POLL_MS_6;
         4'h7:    poll_ms = `SWTC_POLL_MS_7;
         4'h8:    poll_ms = `SWTC_POLL_MS_8;
         4'h9:    poll_ms = `SWTC_POLL_MS_9;
         4'hA:    poll_ms = `SWTC_POLL_MS_A;
         4'hB:    poll_ms = `SWTC_POLL_MS_B;
         4'hC:    poll_ms = `SWTC_POLL_MS_C;
         4'hD:    poll_ms = `SWTC_POLL_MS_D;
         4'hE:    poll_ms = `SWTC_POLL_MS_E;
         default: poll_ms = `SWTC_POLL_MS_F;
      endcase
   end

   // ----------------------------------------------------------------
   // millisecond tick and timers
   // ----------------------------------------------------------------
   reg  [`SWTC_TICK_W-1:0] tick_cnt;
   wire ms_tick = (tick_cnt == `SWTC_MS_LAST);

   always @(posedge clk or posedge reset)
   begin
      if (reset)
         tick_cnt <= {`SWTC_TICK_W{1'b0}};
      else if (!sleep_mode || ms_tick)
         tick_cnt <= {`SWTC_TICK_W{1'b0}};
      else
         tick_cnt <= tick_cnt + {{(`SWTC_TICK_W-1){1'b0}}, 1'b1};
   end

   wire any_wake_en = (|wake_mask_selectable) | (|wake_mask_ground);
   wire wake_run    = sleep_mode && (wake_code != `SWTC_WAKE_OFF);
   wire poll_run    = sleep_mode && any_wake_en;
   wire wake_exp;
   wire poll_exp;

   swtc_ms_timer u_wake_timer
   (
      .clk       (clk),
      .reset     (reset),
      .run       (wake_run),
      .period_ms (wake_ms),
      .ms_tick   (ms_tick),
      .expired   (wake_exp)
   );

   swtc_ms_timer u_poll_timer
   (
      .clk       (clk),
      .reset     (reset),
      .run       (poll_run),
      .period_ms (poll_ms),
      .ms_tick   (ms_tick),
      .expired   (poll_exp)
   );

   // ----------------------------------------------------------------
   // polling window, sampling and wake decision
   // ----------------------------------------------------------------
   reg  [`SWTC_ACT_W-1:0]    act_cnt;
   reg  [`SWTC_WMSEL_W-1:0]  last_sel;
   reg  [`SWTC_WMGND_W-1:0]  last_gnd;
   wire window_end = current_source_en && (act_cnt == `SWTC_ACT_LAST);
   wire [`SWTC_WMSEL_W-1:0] sel_chg = (selectable_channel_state ^ last_sel) & wake_mask_selectable;
   wire [`SWTC_WMGND_W-1:0] gnd_chg = (ground_switch_channel_state ^ last_gnd) & wake_mask_ground;

   always @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         act_cnt           <= {`SWTC_ACT_W{1'b0}};
         current_source_en <= 1'b0;
         sample_strobe     <= 1'b0;
         poll_running      <= 1'b0;
         last_sel          <= {`SWTC_WMSEL_W{1'b0}};
         last_gnd          <= {`SWTC_WMGND_W{1'b0}};
         wake_request      <= 1'b0;
         irq_pending_flag  <= 1'b0;
      end
      else
      begin
         poll_running  <= poll_run;
         sample_strobe <= window_end;
         if (!sleep_mode)
         begin
            current_source_en <= 1'b0;
            act_cnt           <= {`SWTC_ACT_W{1'b0}};
            wake_request      <= 1'b0;
            // reference states track the switches while awake
            last_sel          <= selectable_channel_state;
            last_gnd          <= ground_switch_channel_state;
         end
         else if (poll_exp)
         begin
            current_source_en <= 1'b1;
            act_cnt           <= {`SWTC_ACT_W{1'b0}};
         end
         else if (window_end)
         begin
            current_source_en <= 1'b0;
            if ((|sel_chg) || (|gnd_chg))
               wake_request <= 1'b1;
            last_sel <= selectable_channel_state;
            last_gnd <= ground_switch_channel_state;
         end
         else if (current_source_en)
            act_cnt <= act_cnt + {{(`SWTC_ACT_W-1){1'b0}}, 1'b1};
         if (sleep_mode && wake_exp)
            wake_request <= 1'b1;
         // set wins over clear
         if (sleep_mode && wake_exp)
            irq_pending_flag <= 1'b1;
         else if (irq_clear)
            irq_pending_flag <= 1'b0;
      end
   end
endmodule
`default_nettype wire

/* sim/swtc_monitor.sv */
// port assertions for the sleep wake timer core
`timescale 1ns/1ps
`default_nettype none
`include "swtc_map.vh"
module swtc_monitor
(
   input wire logic        clk,
   input wire logic        reset,
   input wire logic        frame_valid,
   input wire logic [31:0] frame_in,
   input wire logic        fault_summary,
   input wire logic        sleep_mode,
   input wire logic [31:0] frame_out,
   input wire logic        frame_out_valid,
   input wire logic        wake_request,
   input wire logic        irq_pending_flag,
   input wire logic        current_source_en,
   input wire logic        sample_strobe,
   input wire logic        poll_running
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   // length of the current-source window so far
   logic [11:0] act_cnt;
   always @(posedge clk or posedge reset)
      if (reset)
         act_cnt <= 12'h0;
      else if (current_source_en)
         act_cnt <= act_cnt + 12'h1;
      else
         act_cnt <= 12'h0;
   chk_reply_next: assert property (frame_valid |=> frame_out_valid)
      else $error("reply missing");
   chk_reply_alone: assert property (!frame_valid |=> !frame_out_valid)
      else $error("reply without frame");
   chk_reply_head: assert property (
      frame_valid |=> frame_out[31:24] == $past(frame_in[31:24]))
      else $error("reply header wrong");
   chk_fault_copy: assert property (
      frame_valid |=> frame_out[23] == $past(fault_summary))
      else $error("fault bit wrong");
   chk_irq_copy: assert property (
      frame_valid |=> frame_out[22] == $past(irq_pending_flag))
      else $error("irq bit wrong");
   chk_sel_unused: assert property (
      frame_valid && frame_in[31:25] == 7'h10 |=> frame_out[21:8] == 14'h0)
      else $error("selectable mask unused bits set");
   chk_gnd_unused: assert property (
      frame_valid && frame_in[31:25] == 7'h11 |=> frame_out[21:14] == 8'h0)
      else $error("ground mask unused bits set");
   chk_window_len: assert property (
      $fell(current_source_en) && $past(sleep_mode) |-> act_cnt == `SWTC_ACTIVE_CYC)
      else $error("active window length wrong");
   chk_sample_after: assert property (
      $fell(current_source_en) && $past(sleep_mode) |-> ##[0:1] sample_strobe)
      else $error("no sample after window");
   chk_strobe_pulse: assert property (sample_strobe |=> !sample_strobe)
      else $error("sample strobe too long");
   chk_poll_awake: assert property (!sleep_mode |=> !poll_running)
      else $error("polling outside sleep");
   chk_wake_awake: assert property (!sleep_mode |=> !wake_request)
      else $error("wake held outside sleep");
   chk_irq_sleep: assert property ($rose(irq_pending_flag) |-> $past(sleep_mode))
      else $error("irq raised while awake");
endmodule
bind swtc_core swtc_monitor u_mon (.clk, .reset, .frame_valid, .frame_in, .fault_summary,
   .sleep_mode, .frame_out, .frame_out_valid, .wake_request, .irq_pending_flag,
   .current_source_en, .sample_strobe, .poll_running);
`default_nettype wire

/* sim/swtc_host.sv */
// host model issuing register frames and noting expected replies
`timescale 1ns/1ps
`default_nettype none
module swtc_host
(
   input  wire logic        clk,
   output var  logic        frame_valid,
   output var  logic [31:0] frame_in,
   output var  logic        fault_summary
);
   logic [31:0] q[$];
   initial
   begin
      frame_valid = 1'h0;
      frame_in = 32'h0;
      fault_summary = 1'h0;
   end
   // one frame per call; back to back calls give one frame per cycle
   task automatic xfer(input logic [6:0] a, input logic w, input logic [23:0] dat,
                       input logic [21:0] old);
      logic f;
      f = $urandom;
      @(posedge clk);
      #1;
      frame_valid = 1'h1;
      frame_in = {a, w, dat};
      fault_summary = f;
      q.push_back({a, w, f, 1'h0, old});
   endtask
   // released bus carries no stale frame
   task automatic idle();
      @(posedge clk);
      #1;
      frame_valid = 1'h0;
      frame_in = ~frame_in;
   endtask
endmodule
`default_nettype wire

/* sim/tb_sleep_wake_timer_config.sv */
// self-checking testbench for the sleep wake timer core
`timescale 1ns/1ps
`default_nettype none
`include "swtc_map.vh"
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin err_total++; \
   $display("ERROR t=%0t got %h exp %h", $time, a, e); end end
module tb_sleep_wake_timer_config;
   logic        clk, reset, irq_clear, sleep_mode;
   logic [7:0]  selectable_channel_state;
   logic [13:0] ground_switch_channel_state;
   wire         frame_valid, fault_summary;
   wire  [31:0] frame_in;
   wire  [31:0] frame_out;
   wire         frame_out_valid, wake_request, irq_pending_flag;
   wire         current_source_en, sample_strobe, poll_running;
   int          err_total, n_compared, cyc, i;
   logic [23:0] d;
   logic [31:0] ex;
   swtc_host h (.clk, .frame_valid, .frame_in, .fault_summary);
   swtc_core DUT (.clk, .reset, .frame_valid, .frame_in, .fault_summary, .sleep_mode,
      .selectable_channel_state, .ground_switch_channel_state, .irq_clear, .frame_out,
      .frame_out_valid, .wake_request, .irq_pending_flag, .current_source_en,
      .sample_strobe, .poll_running);
   task automatic finish_test();
      $display("compared %0d errors %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task automatic settle(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   initial
   begin
      clk = 1'h0;
      forever #20 clk = ~clk;
   end
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 95000)
      begin
         err_total++;
         finish_test();
      end
   end
   // ----
   // reply checker
   // ----
   always @(negedge clk)
      if (frame_out_valid === 1'h1)
      begin
         ex = h.q.pop_front();
         `CHK(frame_out, ex)
      end
   initial
   begin
      reset = 1'h1;
      irq_clear = 1'h0;
      sleep_mode = 1'h0;
      selectable_channel_state = 8'h0;
      ground_switch_channel_state = 14'h0;
      void'($urandom(14));
      settle(16);
      reset = 1'h0;
      d = $urandom;
      h.xfer(7'h10, 1'h0, 24'h0, 22'hFF);
      h.xfer(7'h11, 1'h0, 24'h0, 22'h3FFF);
      h.xfer(7'h0F, 1'h0, 24'h0, 22'h0F);
      h.xfer(7'h10, 1'h1, d, 22'hFF);
      h.xfer(7'h10, 1'h0, 24'h0, {14'h0, d[7:0]});
      h.xfer(7'h11, 1'h1, d, 22'h3FFF);
      h.xfer(7'h11, 1'h0, 24'h0, {8'h0, d[13:0]});
      h.xfer(7'h12, 1'h1, d, 22'h0);
      h.xfer(7'h12, 1'h0, 24'h0, 22'h0);
      h.xfer(7'h10, 1'h1, 24'h0, {14'h0, d[7:0]});
      h.xfer(7'h11, 1'h1, 24'h0, {8'h0, d[13:0]});
      h.xfer(7'h0F, 1'h1, 24'h0, 22'h0F);
      h.idle();
      // all wake bits clear: no polling, no wake
      sleep_mode = 1'h1;
      settle(20);
      selectable_channel_state = 8'hFF;
      ground_switch_channel_state = 14'h3FFF;
      settle(20);
      `CHK(poll_running, 1'h0)
      `CHK(wake_request, 1'h0)
      h.xfer(7'h10, 1'h1, 24'h01, 22'h0);
      h.idle();
      sleep_mode = 1'h0;
      h.xfer(7'h10, 1'h0, 24'h0, 22'h0);
      h.xfer(7'h10, 1'h1, 24'h01, 22'h0);
      h.idle();
      // channel 0 enabled, timer off, 3 ms polling
      sleep_mode = 1'h1;
      settle(5);
      selectable_channel_state = 8'hFE;
      ground_switch_channel_state = 14'h0;
      `CHK(poll_running, 1'h1)
      // first poll event 3 ms after sleep entry, then the fixed active window
      i = 5;
      while (current_source_en !== 1'h1 && i < 80000)
      begin
         settle(1);
         i++;
      end
      `CHK((i >= 3 * `SWTC_CLK_KHZ) && (i <= 3 * `SWTC_CLK_KHZ + 2), 1'h1)
      i = 0;
      while (sample_strobe !== 1'h1 && i < 3000)
      begin
         settle(1);
         i++;
      end
      `CHK(i, `SWTC_ACTIVE_CYC)
      `CHK(current_source_en, 1'h0)
      `CHK(sample_strobe, 1'h1)
      settle(2);
      `CHK(wake_request, 1'h1)
      `CHK(irq_pending_flag, 1'h0)
      irq_clear = 1'h1;
      sleep_mode = 1'h0;
      settle(1);
      irq_clear = 1'h0;
      settle(1);
      `CHK(wake_request, 1'h0)
      finish_test();
   end
endmodule
`default_nettype wire
